/* File: src/branch_imm_unpack.sv */
`timescale 1ns/100ps

module branch_imm_unpack (
  // instruction word
  input  wire logic [31:0] instr_word,
  // unpacked immediates
  output logic      [31:0] branch_offset_imm,
  output logic      [31:0] branch_compare_imm
);

  // scattered offset bits reassembled, already shifted left by one, sign-extended
  assign branch_offset_imm  = {{19{instr_word[31]}}, instr_word[31], instr_word[7],
                               instr_word[30:25], instr_word[11:8], 1'b0};  // [RULE_10] [RULE_12]
  // signed five-bit compare value from bits 24:20
  assign branch_compare_imm = {{27{instr_word[24]}}, instr_word[24:20]};    // [RULE_12]

endmodule

/* File: src/custom_alu_branch_decoder.sv */
// Operation
// [RULE_01] abs, signed and unsigned set-less-equal
// [RULE_02] signed/unsigned minimum and maximum
// [RULE_03] half-word and byte extension, rs2 zero
// [RULE_04] immediate clip with five-bit width
// [RULE_05] clip bounded by register rs2
// [RULE_06] add: variant bits 31:30, shift 29:25
// [RULE_07] subtract: same variant and shift fields
// [RULE_08] register-shift add, four variants
// [RULE_09] register-shift subtract, four variants
// [RULE_10] branch when rs1 equals compare immediate
// [RULE_11] branch when rs1 differs from immediate
// [RULE_12] branch opcode and immediate bit layout
// [RULE_13] shift right, rounding term for shift nonzero; round_en here follows the variant bit even for shift zero
// [RULE_14] register shift uses rD, rs2[4:0]
// [RULE_15] register bound clears bit 31 first
// [RULE_16] extension widths sixteen or eight bits
// [RULE_17] unmatched custom encodings flagged illegal
`timescale 1ns/100ps

module custom_alu_branch_decoder
  import custom_dec_pkg::*;
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  // instruction from fetch
  input  wire logic                 instr_valid,
  input  wire logic [31:0]          instr_word,
  // decode status
  output logic                      dec_valid,
  output logic                      custom_hit,
  output logic                      illegal_instr,
  output custom_dec_pkg::op_t       alu_op,
  // register operands
  output logic [4:0]                rs1_addr,
  output logic [4:0]                rs2_addr,
  output logic [4:0]                rd_addr,
  output logic                      rd_as_source,
  // shift, clip and extension controls
  output logic [1:0]                variant_select_field,
  output logic                      round_en,
  output logic                      arith_shift,
  output logic                      shift_from_reg,
  output logic [4:0]                shift_amount_imm,
  output logic [4:0]                clip_width_imm,
  output logic                      bound_clear_msb,
  output logic [4:0]                extend_width,
  // branch controls
  output logic                      branch_on_equal,
  output logic [31:0]               branch_offset_imm,
  output logic [31:0]               branch_compare_imm
);

  // reset synchroniser
  logic        rst_q1;          // first stage, read only by second
  logic        rst_n_sync;      // released reset for the design

  // field slices of the incoming word
  logic [6:0]  opc;
  logic [2:0]  f3;
  logic [6:0]  f7;
  logic [4:0]  rs2f;

  // next values from the decoder
  op_t         next_op;
  logic        next_custom;
  logic        next_legal;
  logic [1:0]  next_variant;
  logic        next_shift_reg;
  logic        next_rd_src;
  logic [31:0] off_c;           // unpacked branch offset
  logic [31:0] cmp_c;           // unpacked compare value

  assign opc  = instr_word[6:0];
  assign f3   = instr_word[14:12];
  assign f7   = instr_word[31:25];
  assign rs2f = instr_word[24:20];

  // two-flop release of the asynchronous reset
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_q1     <= 1'b0;
      rst_n_sync <= 1'b0;
    end
    else
    begin
      rst_q1     <= 1'b1;
      rst_n_sync <= rst_q1;
    end
  end

  // branch immediates unpacked aside
  branch_imm_unpack u_branch_imm (
    .instr_word         (instr_word),
    .branch_offset_imm  (off_c),
    .branch_compare_imm (cmp_c)
  );

  // combinational decode of opcode, funct3 and funct7
  always_comb
  begin
    next_op        = op_none;
    next_custom    = 1'b0;
    next_legal     = 1'b0;
    next_variant   = instr_word[31:30];
    next_shift_reg = 1'b0;
    next_rd_src    = 1'b0;
    case (opc)
      OPC_ALU:
      begin
        next_custom = 1'b1;
        next_legal  = (f3 == F3_ALU);  // [RULE_17]
        case (f7)
          F7_ABS:
          begin
            next_op    = absolute_value_op;             // [RULE_01]
            next_legal = next_legal && (rs2f == RS2_NONE);  // [RULE_17]
          end
          F7_SLE:    next_op = set_le_signed_op;        // [RULE_01]
          F7_SLEU:   next_op = set_le_unsigned_op;      // [RULE_01]
          F7_MIN:    next_op = minimum_signed_op;       // [RULE_02]
          F7_MINU:   next_op = minimum_unsigned_op;     // [RULE_02]
          F7_MAX:    next_op = maximum_signed_op;       // [RULE_02]
          F7_MAXU:   next_op = maximum_unsigned_op;     // [RULE_02]
          F7_EXTHS, F7_EXTHZ, F7_EXTBS, F7_EXTBZ:
          begin
            // order: sign half, zero half, sign byte, zero byte
            next_op    = op_t'({3'b010, f7[1:0]});      // [RULE_03]
            next_legal = next_legal && (rs2f == RS2_NONE);  // [RULE_03] [RULE_17]
          end
          F7_CLIP:   next_op = saturate_signed_imm_op;    // [RULE_04]
          F7_CLIPU:  next_op = saturate_unsigned_imm_op;  // [RULE_04]
          F7_CLIPR:  next_op = saturate_signed_reg_op;    // [RULE_05]
          F7_CLIPUR: next_op = saturate_unsigned_reg_op;  // [RULE_05]
          default:
          begin
            // register-shift groups carry the variant in funct7[1:0]
            next_variant   = f7[1:0];                     // [RULE_08] [RULE_09]
            next_shift_reg = 1'b1;                        // [RULE_14]
            next_rd_src    = 1'b1;                        // [RULE_14]
            if (f7[6:2] == F7_ADD_REG_HI)
              next_op = add_regshift_op;                  // [RULE_08]
            else if (f7[6:2] == F7_SUB_REG_HI)
              next_op = sub_regshift_op;                  // [RULE_09]
            else
              next_legal = 1'b0;                          // [RULE_17]
          end
        endcase
      end
      OPC_NORM:
      begin
        // only the add and subtract funct3 values exist; anything else is cleared below
        next_custom = 1'b1;
        next_legal  = (f3 == F3_NORM_ADD) || (f3 == F3_NORM_SUB);                   // [RULE_17]
        next_op     = (f3 == F3_NORM_SUB) ? sub_normalise_op : add_normalise_op;    // [RULE_06] [RULE_07]
      end
      OPC_BRANCH:
      begin
        // equal and not-equal forms; other funct3 values are cleared below
        next_custom = 1'b1;
        next_legal  = (f3 == F3_BR_EQ) || (f3 == F3_BR_NE);                         // [RULE_12] [RULE_17]
        next_op     = (f3 == F3_BR_NE) ? branch_not_equal_imm_op : branch_equal_imm_op;  // [RULE_10] [RULE_11]
      end
      default: next_custom = 1'b0;  // not ours, left to base decode
    endcase
    if (!next_legal)
    begin
      next_op        = op_none;
      next_shift_reg = 1'b0;
      next_rd_src    = 1'b0;
    end
  end

  // valid, hit and illegal flags, one pulse per accepted word
  always_ff @(posedge sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      dec_valid     <= 1'b0;
      custom_hit    <= 1'b0;
      illegal_instr <= 1'b0;
    end
    else
    begin
      dec_valid     <= instr_valid;
      custom_hit    <= instr_valid && next_custom;
      illegal_instr <= instr_valid && next_custom && !next_legal;  // [RULE_17]
    end
  end

  // operation and register fields, held until the next word
  always_ff @(posedge sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      alu_op       <= op_none;
      rs1_addr     <= 5'h00;
      rs2_addr     <= 5'h00;
      rd_addr      <= 5'h00;
      rd_as_source <= 1'b0;
    end
    else if (instr_valid)
    begin
      alu_op       <= next_op;
      rs1_addr     <= instr_word[19:15];
      rs2_addr     <= rs2f;
      rd_addr      <= instr_word[11:7];
      rd_as_source <= next_rd_src;  // [RULE_14]
    end
  end

  // shift, rounding, clip and extension controls
  always_ff @(posedge sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      variant_select_field <= 2'h0;
      round_en             <= 1'b0;
      arith_shift          <= 1'b0;
      shift_from_reg       <= 1'b0;
      shift_amount_imm     <= 5'h00;
      clip_width_imm       <= 5'h00;
      bound_clear_msb      <= 1'b0;
      extend_width         <= 5'h00;
    end
    else if (instr_valid)
    begin
      variant_select_field <= next_variant;                       // [RULE_06] [RULE_07]
      // rounding term enable follows the variant bit, also when the shift amount is zero
      round_en             <= next_variant[VAR_ROUND_BIT];        // [RULE_13]
      arith_shift          <= !next_variant[VAR_LOGIC_BIT];       // [RULE_13]
      shift_from_reg       <= next_shift_reg;                     // [RULE_14]
      shift_amount_imm     <= instr_word[29:25];                  // [RULE_06] [RULE_07]
      clip_width_imm       <= rs2f;                               // [RULE_04]
      bound_clear_msb      <= (next_op == saturate_signed_reg_op) ||
                              (next_op == saturate_unsigned_reg_op);  // [RULE_15]
      // width of the kept low part: sixteen for half, eight for byte
      extend_width         <= (next_op == sign_extend_half_op || next_op == zero_extend_half_op) ? 5'h10 :
                              (next_op == sign_extend_byte_op || next_op == zero_extend_byte_op) ? 5'h08 :
                              5'h00;                              // [RULE_16]
    end
  end

  // branch controls
  always_ff @(posedge sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      branch_on_equal    <= 1'b0;
      branch_offset_imm  <= 32'h0000_0000;
      branch_compare_imm <= 32'h0000_0000;
    end
    else if (instr_valid)
    begin
      branch_on_equal    <= (next_op == branch_equal_imm_op);  // [RULE_10] [RULE_11]
      branch_offset_imm  <= off_c;                             // [RULE_12]
      branch_compare_imm <= cmp_c;                             // [RULE_12]
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_sync);
  // a word of a given alu funct7 arrives
  sequence s_alu(logic [6:0] code);
    instr_valid && opc == OPC_ALU && f3 == F3_ALU && f7 == code;
  endsequence
  a_abs_decode: assert property ( // [RULE_01]
    s_alu(F7_ABS) ##0 (rs2f == RS2_NONE) |=> alu_op == absolute_value_op && !illegal_instr)
    else $error("abs not decoded");
  a_minmax_map: assert property (s_alu(F7_MAXU) |=> alu_op == maximum_unsigned_op && dec_valid) // [RULE_02]
    else $error("unsigned max not decoded");
  a_ext_nonzero: assert property ( // [RULE_03]
    s_alu(F7_EXTBS) ##0 (rs2f != RS2_NONE) |=> illegal_instr && alu_op == op_none)
    else $error("extension with rs2 set not refused");
  a_clip_width: assert property ( // [RULE_04]
    s_alu(F7_CLIP) |=> clip_width_imm == $past(rs2f) && alu_op == saturate_signed_imm_op)
    else $error("clip width wrong");
  a_clip_reg: assert property (s_alu(F7_CLIPUR) |=> bound_clear_msb && alu_op == saturate_unsigned_reg_op) // [RULE_05]
    else $error("register clip wrong");
  a_norm_fields: assert property (instr_valid && opc == OPC_NORM && f3 == F3_NORM_SUB // [RULE_07]
    |=> alu_op == sub_normalise_op && variant_select_field == $past(instr_word[31:30])
        && shift_amount_imm == $past(instr_word[29:25]))
    else $error("normalise fields wrong");
  a_regshift_ctl: assert property ( // [RULE_08]
    instr_valid && opc == OPC_ALU && f3 == F3_ALU && f7[6:2] == F7_ADD_REG_HI
    |=> alu_op == add_regshift_op && shift_from_reg && rd_as_source && variant_select_field == $past(f7[1:0]))
    else $error("register-shift add wrong");
  a_branch_off: assert property (instr_valid && opc == OPC_BRANCH && f3 == F3_BR_NE // [RULE_12]
    |=> !branch_on_equal && branch_offset_imm[12:1] == {$past(instr_word[31]), $past(instr_word[7]),
        $past(instr_word[30:25]), $past(instr_word[11:8])} && branch_offset_imm[0] == 1'b0)
    else $error("branch offset wrong");
  a_bad_funct3: assert property (instr_valid && opc == OPC_NORM && f3 != F3_NORM_ADD && f3 != F3_NORM_SUB
    |=> illegal_instr ##1 (!illegal_instr || $past(instr_valid))) // [RULE_17]
    else $error("bad funct3 not flagged");

endmodule

/* File: src/custom_dec_pkg.sv */
package custom_dec_pkg;

  // major opcodes of the custom encodings
  localparam logic [6:0] OPC_ALU       = 7'h2B;  // general alu, 0101011
  localparam logic [6:0] OPC_NORM      = 7'h5B;  // add/sub with immediate shift, 1011011
  localparam logic [6:0] OPC_BRANCH    = 7'h0B;  // immediate branches, 0001011

  // funct3 values
  localparam logic [2:0] F3_ALU        = 3'h3;
  localparam logic [2:0] F3_NORM_ADD   = 3'h2;
  localparam logic [2:0] F3_NORM_SUB   = 3'h3;
  localparam logic [2:0] F3_BR_EQ      = 3'h6;   // equal-compare branch
  localparam logic [2:0] F3_BR_NE      = 3'h7;

  // funct7 values under the general alu opcode
  localparam logic [6:0] F7_ABS        = 7'h28;
  localparam logic [6:0] F7_SLE        = 7'h29;
  localparam logic [6:0] F7_SLEU       = 7'h2A;
  localparam logic [6:0] F7_MIN        = 7'h2B;
  localparam logic [6:0] F7_MINU       = 7'h2C;
  localparam logic [6:0] F7_MAX        = 7'h2D;
  localparam logic [6:0] F7_MAXU       = 7'h2E;
  localparam logic [6:0] F7_EXTHS      = 7'h30;
  localparam logic [6:0] F7_EXTHZ      = 7'h31;
  localparam logic [6:0] F7_EXTBS      = 7'h32;
  localparam logic [6:0] F7_EXTBZ      = 7'h33;
  localparam logic [6:0] F7_CLIP       = 7'h38;
  localparam logic [6:0] F7_CLIPU      = 7'h39;
  localparam logic [6:0] F7_CLIPR      = 7'h3A;
  localparam logic [6:0] F7_CLIPUR     = 7'h3B;
  // upper five funct7 bits of the register-shift groups; low two bits are the variant
  localparam logic [4:0] F7_ADD_REG_HI = 5'h10;
  localparam logic [4:0] F7_SUB_REG_HI = 5'h11;

  // rs2 field value demanded by single-source operations
  localparam logic [4:0] RS2_NONE      = 5'h00;

  // variant select bit meanings
  localparam int VAR_ROUND_BIT         = 1;  // set: add rounding term first
  localparam int VAR_LOGIC_BIT         = 0;  // set: logical shift, clear: arithmetic

  // decoded operation classes
  typedef enum logic [4:0] {
    op_none                  = 5'b00000,
    absolute_value_op        = 5'b00001,
    set_le_signed_op         = 5'b00010,
    set_le_unsigned_op       = 5'b00011,
    minimum_signed_op        = 5'b00100,
    minimum_unsigned_op      = 5'b00101,
    maximum_signed_op        = 5'b00110,
    maximum_unsigned_op      = 5'b00111,
    sign_extend_half_op      = 5'b01000,
    zero_extend_half_op      = 5'b01001,
    sign_extend_byte_op      = 5'b01010,
    zero_extend_byte_op      = 5'b01011,
    saturate_signed_imm_op   = 5'b01100,
    saturate_unsigned_imm_op = 5'b01101,
    saturate_signed_reg_op   = 5'b01110,
    saturate_unsigned_reg_op = 5'b01111,
    add_normalise_op         = 5'b10000,
    sub_normalise_op         = 5'b10001,
    add_regshift_op          = 5'b10010,
    sub_regshift_op          = 5'b10011,
    branch_equal_imm_op      = 5'b10100,
    branch_not_equal_imm_op  = 5'b10101
  } op_t;

endpackage

/* File: tb/custom_alu_branch_decoder_tb_top.sv */
`timescale 1ns/100ps

module custom_alu_branch_decoder_tb_top;
  import custom_dec_pkg::*;

  logic        sys_clk;               // 40 MHz clock
  logic        arst_n;                // async reset
  logic        instr_valid;           // word strobe from fetch model
  logic [31:0] instr_word;            // word from fetch model
  logic        dec_valid, custom_hit, illegal_instr, rd_as_source;
  logic        round_en, arith_shift, shift_from_reg, bound_clear_msb, branch_on_equal;
  op_t         alu_op;                // decoded operation
  logic [4:0]  rs1_addr, rs2_addr, rd_addr, shift_amount_imm, clip_width_imm, extend_width;
  logic [1:0]  variant_select_field;  // add/sub variant
  logic [31:0] branch_offset_imm, branch_compare_imm;
  int          n_errors = 0;          // mismatches
  int          n_checks = 0;          // comparisons

  // clock: invert each half period
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  fetch_model fetch (.sys_clk(sys_clk), .instr_valid(instr_valid), .instr_word(instr_word));

  custom_alu_branch_decoder dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .dec_valid(dec_valid), .custom_hit(custom_hit), .illegal_instr(illegal_instr), .alu_op(alu_op),
    .rs1_addr(rs1_addr), .rs2_addr(rs2_addr), .rd_addr(rd_addr), .rd_as_source(rd_as_source),
    .variant_select_field(variant_select_field), .round_en(round_en), .arith_shift(arith_shift),
    .shift_from_reg(shift_from_reg), .shift_amount_imm(shift_amount_imm), .clip_width_imm(clip_width_imm),
    .bound_clear_msb(bound_clear_msb), .extend_width(extend_width), .branch_on_equal(branch_on_equal),
    .branch_offset_imm(branch_offset_imm), .branch_compare_imm(branch_compare_imm));

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one comparison, four-state exact
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one word through, leaves us half a cycle after the taking edge
  task automatic take(input logic [31:0] w);
    fetch.present(w);
    fetch.idle();
  endtask

  // status and register fields common to every word
  task automatic chk_base(input logic [31:0] w, input op_t op, input logic hit, input logic ill);
    chk("dec_valid", 1, dec_valid);
    chk("custom_hit", hit, custom_hit);
    chk("illegal_instr", ill, illegal_instr);
    chk("alu_op", op, alu_op);
    chk("rs1_addr", w[19:15], rs1_addr);
    chk("rs2_addr", w[24:20], rs2_addr);
    chk("rd_addr", w[11:7], rd_addr);
  endtask

  // funct7 28 to 3B of the general alu opcode; clip width at its top value
  task automatic s_alu_table();
    logic [6:0]  f7 [15] = '{7'h28, 7'h29, 7'h2A, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h30, 7'h31, 7'h32,
                             7'h33, 7'h38, 7'h39, 7'h3A, 7'h3B};
    op_t         ops [15] = '{absolute_value_op, set_le_signed_op, set_le_unsigned_op, minimum_signed_op,
                             minimum_unsigned_op, maximum_signed_op, maximum_unsigned_op, sign_extend_half_op,
                             zero_extend_half_op, sign_extend_byte_op, zero_extend_byte_op,
                             saturate_signed_imm_op, saturate_unsigned_imm_op, saturate_signed_reg_op,
                             saturate_unsigned_reg_op};
    logic [31:0] w;
    for (int i = 0; i < 15; i++)
    begin
      w = {f7[i], (f7[i] inside {7'h28, [7'h30:7'h33]}) ? 5'h00 : 5'h1F, 5'h0A, 3'h3, 5'h15, 7'h2B};
      take(w);
      chk_base(w, ops[i], 1, 0);
      chk("clip_width_imm", w[24:20], clip_width_imm);
      chk("bound_clear_msb", f7[i] inside {7'h3A, 7'h3B}, bound_clear_msb);
      chk("extend_width", f7[i] inside {7'h30, 7'h31} ? 16 : f7[i] inside {7'h32, 7'h33} ? 8 : 0,
          extend_width);
    end
  endtask

  // immediate-shift add and subtract, all four variants, shift 0 and 31
  task automatic s_norm();
    logic [31:0] w;
    for (int s = 0; s < 2; s++)
      for (int v = 0; v < 4; v++)
      begin
        w = {v[1:0], v[0] ? 5'h1F : 5'h00, 5'h03, 5'h04, s ? 3'h3 : 3'h2, 5'h05, 7'h5B};
        take(w);
        chk_base(w, s ? sub_normalise_op : add_normalise_op, 1, 0);
        chk("variant", v[1:0], variant_select_field);
        chk("round_en", v[1], round_en);
        chk("arith_shift", !v[0], arith_shift);
        chk("shift_amount_imm", w[29:25], shift_amount_imm);
        chk("shift_from_reg", 0, shift_from_reg);
      end
  endtask

  // register-shift add and subtract, funct7 40 to 47
  task automatic s_regshift();
    logic [31:0] w;
    for (int i = 0; i < 8; i++)
    begin
      w = {7'h40 + i[6:0], 5'h1E, 5'h06, 3'h3, 5'h07, 7'h2B};
      take(w);
      chk_base(w, i < 4 ? add_regshift_op : sub_regshift_op, 1, 0);
      chk("variant", i[1:0], variant_select_field);
      chk("round_en", i[1], round_en);
      chk("arith_shift", !i[0], arith_shift);
      chk("rd_as_source", 1, rd_as_source);
      chk("shift_from_reg", 1, shift_from_reg);
    end
  endtask

  // both immediate branches, negative and positive immediates
  task automatic s_branch();
    logic [12:0] o [2] = '{13'h1FFE, 13'h0AAA};
    logic [4:0]  c [2] = '{5'h10, 5'h0F};
    logic [31:0] w;
    for (int i = 0; i < 2; i++)
    begin
      w = {o[i][12], o[i][10:5], c[i], 5'h09, i ? 3'h7 : 3'h6, o[i][4:1], o[i][11], 7'h0B};
      take(w);
      chk_base(w, i ? branch_not_equal_imm_op : branch_equal_imm_op, 1, 0);
      chk("branch_on_equal", !i, branch_on_equal);
      chk("offset", {{19{o[i][12]}}, o[i]}, branch_offset_imm);
      chk("compare", {{27{c[i][4]}}, c[i]}, branch_compare_imm);
    end
  endtask

  // unlisted encodings under each custom opcode, then a foreign opcode
  task automatic s_illegal();
    logic [31:0] w [6] = '{{7'h28, 5'h00, 5'h01, 3'h0, 5'h02, 7'h2B}, {7'h2F, 5'h01, 5'h01, 3'h3, 5'h02, 7'h2B},
                          {7'h28, 5'h01, 5'h01, 3'h3, 5'h02, 7'h2B}, {7'h32, 5'h10, 5'h01, 3'h3, 5'h02, 7'h2B},
                          {7'h00, 5'h01, 5'h01, 3'h0, 5'h02, 7'h5B}, {7'h00, 5'h01, 5'h01, 3'h0, 5'h02, 7'h0B}};
    for (int i = 0; i < 6; i++)
    begin
      take(w[i]);
      chk_base(w[i], op_none, 1, 1);
      chk("rd_as_source", 0, rd_as_source);
      chk("shift_from_reg", 0, shift_from_reg);
    end
    take(32'h0020_81B3);
    chk_base(32'h0020_81B3, op_none, 0, 0);
  endtask

  // back-to-back words, pulse length, hold, then reset in mid-run
  task automatic s_back2back_reset();
    logic [31:0] wa = {7'h28, 5'h00, 5'h01, 3'h3, 5'h02, 7'h2B};
    logic [31:0] wb = {7'h2D, 5'h03, 5'h04, 3'h3, 5'h05, 7'h2B};
    fetch.present(wa);
    fetch.present(wb);
    chk_base(wa, absolute_value_op, 1, 0);
    fetch.idle();
    chk_base(wb, maximum_signed_op, 1, 0);
    @(negedge sys_clk);
    chk("dec_valid_pulse", 0, dec_valid);
    chk("hit_pulse", 0, custom_hit);
    chk("alu_op_hold", maximum_signed_op, alu_op);
    arst_n = 1'b0;
    #1;
    chk("reset_op", op_none, alu_op);
    chk("reset_rs1", 0, rs1_addr);
    chk("reset_offset", 0, branch_offset_imm);
    repeat (2) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    take(wb);
    chk_base(wb, maximum_signed_op, 1, 0);
  endtask

  // hang guard, far beyond the hundred or so cycles the run needs
  initial
  begin
    #(25 * 4000);
    n_errors++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    arst_n = 1'b0;
    repeat (12) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    s_alu_table();
    s_norm();
    s_regshift();
    s_branch();
    s_illegal();
    s_back2back_reset();
    wrap_up();
  end
endmodule

/* File: tb/fetch_model.sv */
`timescale 1ns/100ps

// fetch stage stand-in: hands one word per rising edge, changes only at falling edges
module fetch_model (
  // clock
  input  wire logic        sys_clk,
  // instruction towards the decoder
  output logic             instr_valid,
  output logic [31:0]      instr_word
);
  // idle from time zero, word line carries junk
  initial
  begin
    instr_valid = 1'b0;
    instr_word  = 32'hA5A5_5A5A;
  end

  // present a word so that the next rising edge takes it
  task automatic present(input logic [31:0] w);
    @(negedge sys_clk);
    instr_valid = 1'b1;
    instr_word  = w;
  endtask

  // release; the word line stops showing the last word
  task automatic idle();
    @(negedge sys_clk);
    instr_valid = 1'b0;
    instr_word  = ~instr_word;
  endtask
endmodule
